// [design/pic_ctrl.sv]
// Vectored priority interrupt controller with CPU priority level handling.
// Assumes request and trap inputs are synchronous to clk; one register port.
// Functional notes
// - Each source owns a request flag, set by hardware, cleared by software.
// - Disabled sources are never presented to the processor.
// - Each source has a writable three-bit priority field.
// - On a request, vector number and new level are latched in test status.
// - Latched level equals the reported source's configured priority.
// - Flag, enable and priority bits follow ascending vector number order.
// - Status word bits 7:5 hold the CPU level, software may rewrite them.
// - Core control bit 3 is the level's top bit, software cannot set it.
// - Low bits encode levels 0-7, or 8-15 with top bit; 111 blocks users.
// - Top bit reads 1 above level 7 (trap service), else 0.
// - With nesting disabled the low CPU priority bits are read-only.
// - Control one bit 15 is nesting disable, read/write, reset 0.
// - Control one holds sticky trap flags: arith 4, address 3, stack 2, osc 1.
// - Control two holds external request controls and alternate table select.
`timescale 1ns/1ps
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int unsigned NUM_SRC = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [pic_pkg::PIC_ADDR_W-1:0] reg_addr,
  input wire logic [pic_pkg::PIC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pic_pkg::PIC_DATA_W-1:0] reg_rdata,
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic trap_arith,
  input wire logic trap_address,
  input wire logic trap_stack,
  input wire logic trap_oscillator,
  input wire logic trap_return,
  output logic irq_req,
  output logic [7:0] irq_vector,
  output logic [3:0] irq_level,
  input wire logic irq_ack,
  output logic alt_table_sel,
  output logic [4:0] ext_edge_sel,
  output logic irq_out
);
  import pic_pkg::*;

  localparam int unsigned NWORD = (NUM_SRC + 15) / 16;
  localparam int unsigned NPRIO = (NUM_SRC + PIC_PRIO_PER_REG - 1) / PIC_PRIO_PER_REG;

  logic [NUM_SRC-1:0] flag_r;
  logic [NUM_SRC-1:0] enable_r;
  logic [PIC_PRIO_W-1:0] prio_r [NUM_SRC];
  logic [2:0] cpu_low_r;
  logic cpu_top_r;
  logic nest_dis_r;
  logic [3:0] trap_r;
  logic [15:0] ctrl_two_r;
  logic [7:0] ts_vec_r;
  logic [3:0] ts_lvl_r;
  logic [PIC_EV_W-1:0] ev_stat_r;
  logic [PIC_EV_W-1:0] ev_mask_r;
  logic [15:0] rdata_nxt;

  logic win_found;
  logic [7:0] win_vec;
  logic [2:0] win_prio;
  logic [3:0] cpu_level;
  logic accept;

  assign cpu_level = {cpu_top_r, cpu_low_r};
  assign accept = irq_req & irq_ack;

  function automatic logic wr_at(input logic [7:0] off);
    return reg_wr && (reg_addr == off);
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      localparam logic [7:0] FW = 8'(PIC_OFF_FLAG_BASE + gi / 16);
      localparam logic [7:0] EW = 8'(PIC_OFF_ENABLE_BASE + gi / 16);
      localparam logic [7:0] PW = 8'(PIC_OFF_PRIO_BASE + gi / PIC_PRIO_PER_REG);
      localparam int unsigned FB = gi % 16;
      localparam int unsigned PB = (gi % PIC_PRIO_PER_REG) * 4;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flag_r[gi] <= 1'b0;
        end else if (src_event[gi]) begin
          flag_r[gi] <= 1'b1;
        end else if (wr_at(FW)) begin
          flag_r[gi] <= reg_wdata[FB];
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          enable_r[gi] <= 1'b0;
        end else if (wr_at(EW)) begin
          enable_r[gi] <= reg_wdata[FB];
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          prio_r[gi] <= PIC_PRIO_OFF;
        end else if (wr_at(PW)) begin
          prio_r[gi] <= reg_wdata[PB +: PIC_PRIO_W];
        end
      end
    end
  endgenerate

  always_comb begin
    win_found = 1'b0;
    win_vec = 8'h00;
    win_prio = 3'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (flag_r[i] && enable_r[i] && (!win_found || prio_r[i] > win_prio)) begin
        win_found = 1'b1;
        win_vec = 8'(i);
        win_prio = prio_r[i];
      end
    end
  end

  assign irq_req = win_found && ({1'b0, win_prio} > cpu_level);
  assign irq_vector = win_vec;
  assign irq_level = {1'b0, win_prio};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_low_r <= PIC_RST_CPU_LOW;
    end else if (accept) begin
      cpu_low_r <= win_prio;
    end else if (wr_at(PIC_OFF_STATUS_WORD) && !nest_dis_r) begin
      cpu_low_r <= reg_wdata[PIC_SR_PRIO_LSB +: 3];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_top_r <= 1'b0;
    end else if (|{trap_arith, trap_address, trap_stack, trap_oscillator}) begin
      cpu_top_r <= 1'b1;
    end else if (trap_return) begin
      cpu_top_r <= 1'b0;
    end else if (wr_at(PIC_OFF_CORE_CTRL) && !reg_wdata[PIC_CORE_TOP_BIT]) begin
      cpu_top_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nest_dis_r <= 1'b0;
    end else if (wr_at(PIC_OFF_CTRL_ONE)) begin
      nest_dis_r <= reg_wdata[PIC_C1_NEST_DIS];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_r <= 4'h0;
    end else begin
      trap_r <= (wr_at(PIC_OFF_CTRL_ONE) ? reg_wdata[PIC_C1_ARITH:PIC_C1_OSC] : trap_r)
        | {trap_arith, trap_address, trap_stack, trap_oscillator};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_two_r <= PIC_RST_WORD;
    end else if (wr_at(PIC_OFF_CTRL_TWO)) begin
      ctrl_two_r <= reg_wdata & PIC_C2_WMASK;
    end
  end
  assign alt_table_sel = ctrl_two_r[PIC_C2_ALT_TABLE];
  assign ext_edge_sel = ctrl_two_r[4:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ts_vec_r <= 8'h00;
      ts_lvl_r <= 4'h0;
    end else if (irq_req) begin
      ts_vec_r <= win_vec;
      ts_lvl_r <= {1'b0, win_prio};
    end
  end

  // Event status: set wins over read clear
  logic [PIC_EV_W-1:0] ev_set;
  assign ev_set = {|{trap_arith, trap_address, trap_stack, trap_oscillator}, accept};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_stat_r <= '0;
    end else if (reg_rd && reg_addr == PIC_OFF_IRQ_STATUS) begin
      ev_stat_r <= ev_set;
    end else begin
      ev_stat_r <= ev_stat_r | ev_set;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ev_mask_r <= '0;
    end else if (wr_at(PIC_OFF_IRQ_MASK)) begin
      ev_mask_r <= reg_wdata[PIC_EV_W-1:0];
    end
  end
  assign irq_out = |(ev_stat_r & ev_mask_r);

  // Read words, one per register
  logic [15:0] rd_status_word;
  logic [15:0] rd_core_ctrl;
  logic [15:0] rd_ctrl_one;
  logic [15:0] rd_ctrl_two;
  logic [15:0] rd_test_status;
  logic [15:0] rd_ev_stat;
  logic [15:0] rd_ev_mask;
  logic [15:0] rd_flag_word [NWORD];
  logic [15:0] rd_enable_word [NWORD];
  logic [15:0] rd_prio_word [NPRIO];

  always_comb begin
    rd_status_word = 16'h0000;
    rd_status_word[PIC_SR_PRIO_LSB +: 3] = cpu_low_r;
  end

  always_comb begin
    rd_core_ctrl = 16'h0000;
    rd_core_ctrl[PIC_CORE_TOP_BIT] = cpu_top_r;
  end

  always_comb begin
    rd_ctrl_one = 16'h0000;
    rd_ctrl_one[PIC_C1_NEST_DIS] = nest_dis_r;
    rd_ctrl_one[PIC_C1_ARITH:PIC_C1_OSC] = trap_r;
  end

  always_comb begin
    rd_ctrl_two = ctrl_two_r;
  end

  always_comb begin
    rd_test_status = 16'h0000;
    rd_test_status[PIC_TS_LEVEL_LSB +: 4] = ts_lvl_r;
    rd_test_status[7:0] = ts_vec_r;
  end

  // Event status and mask views
  always_comb begin
    rd_ev_stat = 16'h0000;
    rd_ev_stat[PIC_EV_W-1:0] = ev_stat_r;
  end
  always_comb begin
    rd_ev_mask = 16'h0000;
    rd_ev_mask[PIC_EV_W-1:0] = ev_mask_r;
  end

  genvar gw;
  generate
    for (gw = 0; gw < NWORD; gw++) begin : g_word
      always_comb begin
        rd_flag_word[gw] = 16'h0000;
        rd_enable_word[gw] = 16'h0000;
        for (int b = 0; b < 16; b++) begin
          if (gw * 16 + b < NUM_SRC) begin
            rd_flag_word[gw][b] = flag_r[gw * 16 + b];
            rd_enable_word[gw][b] = enable_r[gw * 16 + b];
          end
        end
      end
    end
  endgenerate

  genvar gp;
  generate
    for (gp = 0; gp < NPRIO; gp++) begin : g_prio_word
      always_comb begin
        rd_prio_word[gp] = 16'h0000;
        for (int k = 0; k < PIC_PRIO_PER_REG; k++) begin
          if (gp * PIC_PRIO_PER_REG + k < NUM_SRC) begin
            rd_prio_word[gp][k * 4 +: PIC_PRIO_W] = prio_r[gp * PIC_PRIO_PER_REG + k];
          end
        end
      end
    end
  endgenerate

  // Read mux, unmapped offsets read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (reg_addr)
      PIC_OFF_STATUS_WORD: begin
        rdata_nxt = rd_status_word;
      end
      PIC_OFF_CORE_CTRL: begin
        rdata_nxt = rd_core_ctrl;
      end
      PIC_OFF_CTRL_ONE: begin
        rdata_nxt = rd_ctrl_one;
      end
      PIC_OFF_CTRL_TWO: begin
        rdata_nxt = rd_ctrl_two;
      end
      PIC_OFF_TEST_STATUS: begin
        rdata_nxt = rd_test_status;
      end
      PIC_OFF_IRQ_STATUS: begin
        rdata_nxt = rd_ev_stat;
      end
      PIC_OFF_IRQ_MASK: begin
        rdata_nxt = rd_ev_mask;
      end
      default: begin
        for (int w = 0; w < NWORD; w++) begin
          if (reg_addr == 8'(PIC_OFF_FLAG_BASE + w)) begin
            rdata_nxt = rd_flag_word[w];
          end
          if (reg_addr == 8'(PIC_OFF_ENABLE_BASE + w)) begin
            rdata_nxt = rd_enable_word[w];
          end
        end
        for (int w = 0; w < NPRIO; w++) begin
          if (reg_addr == 8'(PIC_OFF_PRIO_BASE + w)) begin
            rdata_nxt = rd_prio_word[w];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // pic_ctrl

// [design/pic_pkg.sv]
// Constants for the prioritized interrupt controller.
// Assumes a 16-bit register port and single clock domain.
package pic_pkg;
  localparam int unsigned PIC_ADDR_W = 8;
  localparam int unsigned PIC_DATA_W = 16;
  // Register offsets (word index on the register port)
  localparam logic [7:0] PIC_OFF_STATUS_WORD = 8'h00;
  localparam logic [7:0] PIC_OFF_CORE_CTRL = 8'h01;
  localparam logic [7:0] PIC_OFF_CTRL_ONE = 8'h02;
  localparam logic [7:0] PIC_OFF_CTRL_TWO = 8'h03;
  localparam logic [7:0] PIC_OFF_TEST_STATUS = 8'h04;
  localparam logic [7:0] PIC_OFF_IRQ_STATUS = 8'h05;
  localparam logic [7:0] PIC_OFF_IRQ_MASK = 8'h06;
  localparam logic [7:0] PIC_OFF_FLAG_BASE = 8'h10;
  localparam logic [7:0] PIC_OFF_ENABLE_BASE = 8'h20;
  localparam logic [7:0] PIC_OFF_PRIO_BASE = 8'h30;
  // Field positions
  localparam int unsigned PIC_SR_PRIO_LSB = 5;
  localparam int unsigned PIC_CORE_TOP_BIT = 3;
  localparam int unsigned PIC_C1_NEST_DIS = 15;
  localparam int unsigned PIC_C1_ARITH = 4;
  localparam int unsigned PIC_C1_ADDR = 3;
  localparam int unsigned PIC_C1_STACK = 2;
  localparam int unsigned PIC_C1_OSC = 1;
  localparam int unsigned PIC_C2_ALT_TABLE = 15;
  localparam int unsigned PIC_TS_LEVEL_LSB = 8;
  localparam int unsigned PIC_PRIO_W = 3;
  localparam int unsigned PIC_PRIO_PER_REG = 4;
  // Controls of interrupt_control_two that are writable
  localparam logic [15:0] PIC_C2_WMASK = 16'h801F;
  // Reset values and trap service level
  localparam logic [15:0] PIC_RST_WORD = 16'h0000;
  localparam logic [2:0] PIC_RST_CPU_LOW = 3'h0;
  localparam logic [2:0] PIC_PRIO_OFF = 3'h0;
  localparam logic [3:0] PIC_TRAP_LEVEL = 4'h8;
  // Event status bits
  localparam int unsigned PIC_EV_ACCEPT = 0;
  localparam int unsigned PIC_EV_TRAP = 1;
  localparam int unsigned PIC_EV_W = 2;
endpackage

// [tb/pic_checker.sv]
// Port assertions for the interrupt controller.
// Assumes one clock domain; bound into pic_ctrl.
`timescale 1ns/1ps
module pic_checker
  import pic_pkg::*;
#(parameter int unsigned NUM_SRC = 32) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic trap_arith,
  input wire logic trap_address,
  input wire logic trap_stack,
  input wire logic trap_oscillator,
  input wire logic irq_req,
  input wire logic [7:0] irq_vector,
  input wire logic [3:0] irq_level,
  input wire logic irq_ack,
  input wire logic alt_table_sel,
  input wire logic [4:0] ext_edge_sel,
  input wire logic irq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic trap_any;
  logic c2_wr_r;
  logic [15:0] wd_r;
  assign trap_any = trap_arith | trap_address | trap_stack | trap_oscillator;
  always_ff @(posedge clk) begin
    wd_r <= reg_wdata;
  end
  level_form_a: assert property (irq_req |-> !irq_level[3] && irq_level != 4'h0)
    else $error("winner level out of range");
  vec_range_a: assert property (irq_req |-> irq_vector < NUM_SRC)
    else $error("winner vector out of range");
  ack_raise_a: assert property (irq_req && irq_ack |=> !irq_req || irq_level > $past(irq_level))
    else $error("accept did not raise level");
  trap_mask_a: assert property (trap_any |=> !irq_req)
    else $error("request during trap");
  req_hold_a: assert property (irq_req && !irq_ack && !reg_wr && !trap_any |=> irq_req)
    else $error("request dropped by itself");
  alt_table_a: assert property (reg_wr && reg_addr == PIC_OFF_CTRL_TWO |=> alt_table_sel == wd_r[15])
    else $error("table select not updated");
  edge_sel_a: assert property (reg_wr && reg_addr == PIC_OFF_CTRL_TWO |=> ext_edge_sel == wd_r[4:0])
    else $error("edge select not updated");
  mask_off_a: assert property (reg_wr && reg_addr == PIC_OFF_IRQ_MASK && reg_wdata == 16'h0000 ##1 !reg_wr |=> !irq_out)
    else $error("masked interrupt still out");
  cover property (irq_req && irq_ack);
  cover property (trap_any);
  cover property (irq_out);
endmodule // pic_checker

bind pic_ctrl pic_checker #(.NUM_SRC(NUM_SRC)) chk_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .trap_arith, .trap_address, .trap_stack, .trap_oscillator, .irq_req, .irq_vector, .irq_level,
  .irq_ack, .alt_table_sel, .ext_edge_sel, .irq_out);

// [tb/pic_cpu_model.sv]
// Processor model: accepts a request after a chosen delay.
// Assumes irq_req is a level on clk.
`timescale 1ns/1ps
module pic_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [3:0] delay,
  input wire logic irq_req,
  output logic irq_ack
);
  logic [3:0] wait_r;
  assign irq_ack = enable && irq_req && wait_r == delay;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_r <= 4'h0;
    end else if (!irq_req || irq_ack) begin
      wait_r <= 4'h0;
    end else if (enable) begin
      wait_r <= wait_r + 4'h1;
    end
  end
endmodule // pic_cpu_model

// [tb/tb.sv]
// Self-checking bench for the interrupt controller.
// Assumes 32 sources and a processor model on the accept side.
`timescale 1ns/1ps
module tb;
  import pic_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] src_event = 32'h0;
  logic [4:0] trap_v = 5'h00;
  logic ack_en = 1'b0;
  logic [3:0] ack_dly = 4'h0;
  logic [31:0] seed = 32'h00001611;
  logic [31:0] x;
  logic [15:0] reg_rdata;
  logic irq_req, irq_ack, alt_table_sel, irq_out;
  logic [7:0] irq_vector;
  logic [3:0] irq_level;
  logic [4:0] ext_edge_sel;
  int err_count = 0;
  int comparisons = 0;
  int s, p;
  always #2.5 clk = ~clk;
  pic_ctrl #(.NUM_SRC(32)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_event,
    .trap_arith(trap_v[3]), .trap_address(trap_v[2]), .trap_stack(trap_v[1]), .trap_oscillator(trap_v[0]),
    .trap_return(trap_v[4]), .irq_req, .irq_vector, .irq_level, .irq_ack, .alt_table_sel, .ext_edge_sel, .irq_out);
  pic_cpu_model cpu (.clk, .rst, .enable(ack_en), .delay(ack_dly), .irq_req, .irq_ack);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] pw(int s, int p);
    return 16'(p) << (s % 4) * 4;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic pulse(input logic [31:0] ev, input logic [4:0] tr);
    @(posedge clk);
    src_event <= ev;
    trap_v <= tr;
    @(posedge clk);
    src_event <= 32'h0;
    trap_v <= 5'h00;
    #1;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++) rd(8'(a), 16'h0000);
    wr(PIC_OFF_IRQ_MASK, 16'h0003);
    repeat (6) begin
      x = xs();
      s = x % 32;
      p = (x >> 8) % 7 + 1;
      wr(PIC_OFF_PRIO_BASE + 8'(s / 4), pw(s, p));
      pulse(32'h1 << s, 5'h00);
      chk(irq_req, 1'b0);
      wr(PIC_OFF_ENABLE_BASE + 8'(s / 16), 16'h0001 << (s % 16));
      chk({irq_req, irq_vector, irq_level}, {1'b1, 8'(s), 4'(p)});
      rd(PIC_OFF_TEST_STATUS, {4'h0, 4'(p), 8'(s)});
      rd(PIC_OFF_FLAG_BASE + 8'(s / 16), 16'h0001 << (s % 16));
      wr(PIC_OFF_FLAG_BASE + 8'(s / 16), 16'h0000);
      chk(irq_req, 1'b0);
      wr(PIC_OFF_ENABLE_BASE + 8'(s / 16), 16'h0000);
      wr(PIC_OFF_CTRL_TWO, x[31:16]);
      chk({alt_table_sel, ext_edge_sel}, {x[31], x[20:16]});
      rd(PIC_OFF_CTRL_TWO, x[31:16] & PIC_C2_WMASK);
    end
    wr(PIC_OFF_PRIO_BASE, 16'h5000);
    wr(PIC_OFF_PRIO_BASE + 8'h02, 16'h0050);
    wr(PIC_OFF_ENABLE_BASE, 16'h0208);
    pulse(32'h0000_0208, 5'h00);
    for (int l = 7; l >= 0; l--) begin
      wr(PIC_OFF_STATUS_WORD, 16'(l) << 5);
      chk({irq_req, irq_req ? irq_vector : 8'h00}, (l < 5) ? 9'h103 : 9'h000);
    end
    ack_dly <= 4'(xs());
    ack_en <= 1'b1;
    for (int i = 0; i < 40 && irq_ack !== 1'b1; i++) @(posedge clk) #1;
    if (irq_ack !== 1'b1) begin
      err_count++;
      complete_run();
    end
    @(posedge clk);
    ack_en <= 1'b0;
    #1 chk(irq_req, 1'b0);
    rd(PIC_OFF_STATUS_WORD, 16'h00A0);
    wr(PIC_OFF_CTRL_ONE, 16'h8000);
    wr(PIC_OFF_STATUS_WORD, 16'h0000);
    rd(PIC_OFF_STATUS_WORD, 16'h00A0);
    rd(PIC_OFF_CTRL_ONE, 16'h8000);
    wr(PIC_OFF_CTRL_ONE, 16'h0000);
    wr(PIC_OFF_STATUS_WORD, 16'h0000);
    chk(irq_req, 1'b1);
    for (int i = 0; i < 4; i++) begin
      pulse(32'h0, 5'h01 << i);
      chk(irq_req, 1'b0);
      rd(PIC_OFF_CTRL_ONE, (16'h0004 << i) - 16'h0002);
      rd(PIC_OFF_CORE_CTRL, 16'h0008);
    end
    chk(irq_out, 1'b1);
    rd(PIC_OFF_IRQ_STATUS, 16'h0003);
    @(posedge clk);
    #1 chk(irq_out, 1'b0);
    pulse(32'h0, 5'h10);
    rd(PIC_OFF_CORE_CTRL, 16'h0000);
    chk(irq_req, 1'b1);
    wr(PIC_OFF_CORE_CTRL, 16'h0008);
    rd(PIC_OFF_CORE_CTRL, 16'h0000);
    wr(PIC_OFF_IRQ_MASK, 16'h0000);
    rd(PIC_OFF_IRQ_MASK, 16'h0000);
    complete_run();
  end
endmodule // tb
